// ### design/ssm_consts.svh
// constants for the sync supervision monitor
`ifndef SSM_CONSTS_SVH
`define SSM_CONSTS_SVH

// ----------------------------------------
// timing
// ----------------------------------------
`define SSM_CLK_MHZ 200
`define SSM_TOL_NS 2000
`define SSM_TOL_CYC ((`SSM_TOL_NS * `SSM_CLK_MHZ) / 1000)

// ----------------------------------------
// network state encoding and reset values
// ----------------------------------------
`define SSM_NET_OP 4'h8
`define SSM_WARN_RST 1'h0
`define SSM_CNT_RST 8'h00

`endif

// ### design/ssm_monitor.sv
// sync supervision monitor top: warnings for the synchronous link
`timescale 1ns/1ps
`default_nettype none
`include "ssm_consts.svh"

// Behaviour
// [RULE1] sync lost warning when sync events turn abnormal while link is running
// [RULE2] period within 2us of nominal is not a fault
// [RULE3] tolerate allowed_sync_loss_count misses; warn only once allowance is exceeded
// [RULE4] measured period of zero means master sync clock absent
// [RULE5] leaving OP while servo enabled raises sync lost warning
// [RULE6] entering OP, sync cycle must be integer multiple of scheduling cycle
// [RULE7] scheduling cycle is product of two factory factors
// [RULE8] cycle error beyond threshold from allowed_sync_loss_count raises error warning
// [RULE9] missing slave description file raises its warning
// [RULE10] master sends valid, integer multiple, low jitter sync events
// [RULE11] period counted in local cycles; warnings latched until reset or clear
module ssm_monitor
	import ssm_pkg::*;
#(
	parameter int W = 24,
	parameter int FW = 8,
	parameter int CW = 8
) (
	input wire logic clk_i,
	input wire logic reset_i,
	input wire logic sync_event_i,
	input wire logic [3:0] net_state_i,
	input wire logic servo_enabled_i,
	input wire logic [W-1:0] nominal_period_i,
	input wire logic [FW-1:0] sched_factor_a_i,
	input wire logic [FW-1:0] sched_factor_b_i,
	input wire logic [CW-1:0] allowed_sync_loss_count_i,
	input wire logic slave_description_file_i,
	input wire logic clear_warnings_i,
	output logic sync_lost_warning_o,
	output logic description_file_missing_warning_o,
	output logic sync_cycle_setting_warning_o,
	output logic sync_cycle_error_warning_o,
	output logic [W-1:0] measured_period_o,
	output logic [CW-1:0] miss_count_o
);
	localparam logic [W-1:0] TOL_CYC = W'(`SSM_TOL_CYC);

	typedef struct packed {
		logic sync_lost;
		logic desc_missing;
		logic setting;
		logic cyc_err;
		logic was_op;
		logic [CW-1:0] miss;
	} ssm_state_t;

	ssm_state_t q_reg, q_next;

	logic [W-1:0] period;
	logic period_valid;
	logic timeout;
	logic [W-1:0] limit;
	logic [W-1:0] dev;
	logic [W-1:0] err_thr;
	logic [2*FW-1:0] sched_cyc;
	logic running;
	logic entered_op;
	logic left_op;
	logic abnormal;
	logic good;
	logic loss_over;
	logic set_lost;
	logic set_setting;
	logic set_err;
	logic set_desc;

	// ----------------------------------------
	// period measurement
	// ----------------------------------------
	ssm_period_meter #(
		.W(W)
	) u_meter (
		.clk_i(clk_i),
		.reset_i(reset_i),
		.sync_event_i(sync_event_i),
		.limit_i(limit),
		.period_o(period),
		.period_valid_o(period_valid),
		.timeout_o(timeout)
	);

	// ----------------------------------------
	// derived quantities
	// ----------------------------------------
	// timeout window: one nominal cycle plus tolerance
	assign limit = nominal_period_i + TOL_CYC;
	// distance of the measured period from nominal
	assign dev = (period >= nominal_period_i) ? period - nominal_period_i
		: nominal_period_i - period;
	// error threshold scales with the loss allowance
	assign err_thr = W'(TOL_CYC * (W'(allowed_sync_loss_count_i) + 1'b1)); // see [RULE8]
	assign sched_cyc = sched_factor_a_i * sched_factor_b_i; // see [RULE7]
	assign running = (net_state_i == `SSM_NET_OP);
	assign entered_op = running && !q_reg.was_op;
	assign left_op = !running && q_reg.was_op;

	// ----------------------------------------
	// event classification
	// ----------------------------------------
	// zero period or deviation beyond tolerance counts as a miss
	assign good = period_valid && (dev <= TOL_CYC); // see [RULE2]
	assign abnormal = timeout || (period_valid && (dev > TOL_CYC)); // see [RULE4]
	assign loss_over = abnormal && ({1'b0, q_reg.miss} + 1'b1 > {1'b0, allowed_sync_loss_count_i});

	// ----------------------------------------
	// warning set terms
	// ----------------------------------------
	always_comb begin
		set_lost = (running && loss_over); // see [RULE1] see [RULE3]
		if (left_op && servo_enabled_i) begin
			set_lost = 1'b1; // see [RULE5]
		end
		set_setting = 1'b0;
		if (entered_op) begin
			if (sched_cyc == '0) begin
				set_setting = 1'b1;
			end else if ((nominal_period_i % W'(sched_cyc)) != '0) begin
				set_setting = 1'b1; // see [RULE6]
			end
		end
		set_err = period_valid && (dev > err_thr); // see [RULE8]
		set_desc = !slave_description_file_i; // see [RULE9]
	end

	// ----------------------------------------
	// next state: set wins over software clear
	// ----------------------------------------
	always_comb begin
		q_next = q_reg;
		q_next.was_op = running;
		q_next.sync_lost = (q_reg.sync_lost && !clear_warnings_i) || set_lost; // see [RULE11]
		q_next.setting = (q_reg.setting && !clear_warnings_i) || set_setting; // see [RULE11]
		q_next.cyc_err = (q_reg.cyc_err && !clear_warnings_i) || set_err; // see [RULE11]
		q_next.desc_missing = (q_reg.desc_missing && !clear_warnings_i) || set_desc;
		if (!running || good) begin
			q_next.miss = '0;
		end else if (abnormal && q_reg.miss != '1) begin
			q_next.miss = q_reg.miss + 1'b1; // see [RULE3]
		end
	end

	// state register
	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			q_reg <= '{sync_lost: `SSM_WARN_RST, desc_missing: `SSM_WARN_RST,
				setting: `SSM_WARN_RST, cyc_err: `SSM_WARN_RST, was_op: 1'b0,
				miss: CW'(`SSM_CNT_RST)};
		end else begin
			q_reg <= q_next;
		end
	end

	// ----------------------------------------
	// outputs
	// ----------------------------------------
	assign sync_lost_warning_o = q_reg.sync_lost;
	assign description_file_missing_warning_o = q_reg.desc_missing;
	assign sync_cycle_setting_warning_o = q_reg.setting;
	assign sync_cycle_error_warning_o = q_reg.cyc_err;
	assign measured_period_o = period;
	assign miss_count_o = q_reg.miss;

	// ----------------------------------------
	// checks
	// ----------------------------------------
	a_lost_on_loss: assert property (@(posedge clk_i) disable iff (reset_i) // see [RULE1]
		running && timeout && (q_reg.miss >= allowed_sync_loss_count_i)
		|=> sync_lost_warning_o) else $error("sync lost not raised after allowance");

	a_tol_no_miss: assert property (@(posedge clk_i) disable iff (reset_i) // see [RULE2]
		period_valid && dev <= TOL_CYC |=> miss_count_o == '0)
		else $error("period within tolerance counted as miss");

	a_allow_quiet: assert property (@(posedge clk_i) disable iff (reset_i) // see [RULE3]
		!sync_lost_warning_o && running && !left_op && timeout
		&& ({1'b0, q_reg.miss} + 1'b1 <= {1'b0, allowed_sync_loss_count_i})
		|=> !sync_lost_warning_o) else $error("sync lost raised within allowance");

	a_miss_count: assert property (@(posedge clk_i) disable iff (reset_i) // see [RULE4]
		running && timeout && q_reg.miss != '1
		|=> miss_count_o == $past(q_reg.miss) + 1'b1) else $error("zero period not counted");

	a_left_op: assert property (@(posedge clk_i) disable iff (reset_i) // see [RULE5]
		running ##1 !running && servo_enabled_i |=> sync_lost_warning_o)
		else $error("leaving op while enabled not flagged");

	a_bad_multiple: assert property (@(posedge clk_i) disable iff (reset_i) // see [RULE6]
		entered_op && sched_cyc != '0 && (nominal_period_i % W'(sched_cyc)) != '0
		|=> sync_cycle_setting_warning_o) else $error("bad cycle setting not flagged");

	a_good_multiple: assert property (@(posedge clk_i) disable iff (reset_i) // see [RULE7]
		!sync_cycle_setting_warning_o && entered_op && sched_cyc != '0
		&& (nominal_period_i % W'(sched_cyc)) == '0
		|=> !sync_cycle_setting_warning_o) else $error("good cycle setting flagged");

	a_cycle_err: assert property (@(posedge clk_i) disable iff (reset_i) // see [RULE8]
		period_valid && dev > err_thr |=> sync_cycle_error_warning_o)
		else $error("cycle error warning missing");

	a_desc_file: assert property (@(posedge clk_i) disable iff (reset_i) // see [RULE9]
		!slave_description_file_i |=> description_file_missing_warning_o)
		else $error("description file warning missing");

	a_latched: assert property (@(posedge clk_i) disable iff (reset_i) // see [RULE11]
		sync_lost_warning_o && !clear_warnings_i |=> sync_lost_warning_o)
		else $error("warning dropped without clear");
endmodule : ssm_monitor

`default_nettype wire

// ### design/ssm_period_meter.sv
// period meter for the incoming synchronization events
`timescale 1ns/1ps
`default_nettype none
`include "ssm_consts.svh"

module ssm_period_meter
	import ssm_pkg::*;
#(
	parameter int W = 24
) (
	input wire logic clk_i,
	input wire logic reset_i,
	input wire logic sync_event_i,
	input wire logic [W-1:0] limit_i,
	output logic [W-1:0] period_o,
	output logic period_valid_o,
	output logic timeout_o
);
	typedef struct packed {
		ssm_meter_st_t st;
		logic [W-1:0] cnt;
		logic [W-1:0] period;
		logic valid;
		logic tmo;
	} ssm_meter_t;

	ssm_meter_t q_reg, q_next;

	// ----------------------------------------
	// interval counting between events
	// ----------------------------------------
	always_comb begin
		q_next = q_reg;
		q_next.valid = 1'b0;
		q_next.tmo = 1'b0;
		q_next.cnt = q_reg.cnt + 1'b1; // see [RULE11]
		case (q_reg.st)
			SSM_IDLE: begin
				if (sync_event_i) begin
					q_next.st = SSM_ARMED;
					q_next.cnt = {{(W-1){1'b0}}, 1'b1};
				end else if (q_reg.cnt >= limit_i) begin
					q_next.tmo = 1'b1;
					q_next.period = '0; // see [RULE4]
					q_next.cnt = '0;
				end
			end
			default: begin
				if (sync_event_i) begin
					q_next.period = q_reg.cnt; // see [RULE11]
					q_next.valid = 1'b1;
					q_next.cnt = {{(W-1){1'b0}}, 1'b1};
				end else if (q_reg.cnt >= limit_i) begin
					q_next.tmo = 1'b1; // absent clock reads as zero
					q_next.period = '0; // see [RULE4]
					q_next.cnt = '0;
					q_next.st = SSM_IDLE;
				end
			end
		endcase
	end

	// registers
	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			q_reg <= '{st: SSM_IDLE, cnt: '0, period: '0, valid: 1'b0, tmo: 1'b0};
		end else begin
			q_reg <= q_next;
		end
	end

	assign period_o = q_reg.period;
	assign period_valid_o = q_reg.valid;
	assign timeout_o = q_reg.tmo;

	a_zero_on_tmo: assert property (@(posedge clk_i) disable iff (reset_i) // see [RULE4]
		!sync_event_i && q_reg.cnt >= limit_i |=> timeout_o && period_o == '0)
		else $error("period not zero on timeout");
endmodule : ssm_period_meter

`default_nettype wire

// ### design/ssm_pkg.sv
// types shared by the sync supervision monitor
package ssm_pkg;
	typedef enum logic [1:0] {
		SSM_IDLE,
		SSM_ARMED
	} ssm_meter_st_t;
endpackage : ssm_pkg

// ### dv/ssm_master_model.sv
// network master model issuing periodic sync event pulses
`timescale 1ns/1ps
`default_nettype none

module ssm_master_model (
	input wire logic clk_i,
	input wire logic reset_i,
	input wire logic run_i,
	input wire logic [23:0] period_i,
	output logic sync_event_o
);
	logic [23:0] cnt_reg;

	// one-cycle pulse every period_i cycles, line idles low when stopped
	always_ff @(posedge clk_i) begin
		if (reset_i || !run_i) begin
			cnt_reg <= 24'h000000;
			sync_event_o <= 1'h0;
		end else if (cnt_reg >= period_i - 24'h000001) begin
			cnt_reg <= 24'h000000;
			sync_event_o <= 1'h1;
		end else begin
			cnt_reg <= cnt_reg + 24'h000001;
			sync_event_o <= 1'h0;
		end
	end
endmodule : ssm_master_model

`default_nettype wire

// ### dv/ssm_monitor_test.sv
// self-checking bench for the sync supervision monitor
`timescale 1ns/1ps
`default_nettype none

module ssm_monitor_test;
	logic clk_i, reset_i, sync_event_i, servo_enabled_i, slave_description_file_i;
	logic clear_warnings_i, run, lost, desc, setw, errw;
	logic [3:0] net_state_i;
	logic [23:0] nominal_period_i, per, measured;
	logic [7:0] fa, fb, allowed, miss;
	int errors = 0, n_checks = 0, cycles = 0;

	ssm_master_model master (.clk_i(clk_i), .reset_i(reset_i), .run_i(run),
		.period_i(per), .sync_event_o(sync_event_i));

	ssm_monitor dut (.clk_i(clk_i), .reset_i(reset_i), .sync_event_i(sync_event_i),
		.net_state_i(net_state_i), .servo_enabled_i(servo_enabled_i),
		.nominal_period_i(nominal_period_i), .sched_factor_a_i(fa), .sched_factor_b_i(fb),
		.allowed_sync_loss_count_i(allowed), .slave_description_file_i(slave_description_file_i),
		.clear_warnings_i(clear_warnings_i), .sync_lost_warning_o(lost),
		.description_file_missing_warning_o(desc), .sync_cycle_setting_warning_o(setw),
		.sync_cycle_error_warning_o(errw), .measured_period_o(measured), .miss_count_o(miss));

	// ----------------------------------------
	// clock, hang guard, helpers
	// ----------------------------------------
	initial begin
		clk_i = 1'h0;
		forever #2.5 clk_i = ~clk_i;
	end

	always @(posedge clk_i) begin
		cycles++;
		if (cycles == 20000) begin
			errors++;
			summarize();
		end
	end

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		n_checks++;
		if (seen !== exp) begin
			errors++;
			$display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : check

	task automatic settle(input int n);
		repeat (n) @(posedge clk_i);
		@(negedge clk_i);
	endtask : settle

	// waits for a pulse, then for period and warnings to land
	task automatic wait_ev();
		for (int i = 0; i < 3000 && !sync_event_i; i++) @(negedge clk_i);
		check(sync_event_i, 1);
		settle(3);
	endtask : wait_ev

	task automatic clear_all();
		@(posedge clk_i);
		clear_warnings_i <= 1'h1;
		@(posedge clk_i);
		clear_warnings_i <= 1'h0;
		settle(2);
	endtask : clear_all

	task automatic set_state(input logic [3:0] s);
		@(posedge clk_i);
		net_state_i <= s;
		settle(3);
	endtask : set_state

	// ----------------------------------------
	// scenarios
	// ----------------------------------------
	task automatic t_desc();
		check(desc, 1);
		@(posedge clk_i);
		slave_description_file_i <= 1'h1;
		clear_all();
		check(desc, 0);
	endtask : t_desc

	task automatic t_setting();
		set_state(4'h8);
		check(setw, 0);
		@(posedge clk_i);
		servo_enabled_i <= 1'h0;
		set_state(4'h2);
		check(lost, 0);
		@(posedge clk_i);
		nominal_period_i <= 24'h0003e9;
		set_state(4'h8);
		check(setw, 1);
		@(posedge clk_i);
		nominal_period_i <= 24'h0003e8;
		clear_all();
		check(setw, 0);
		// a zero scheduling cycle is a bad setting as well
		@(posedge clk_i);
		fa <= 8'h00;
		set_state(4'h2);
		set_state(4'h8);
		check(setw, 1);
		@(posedge clk_i);
		fa <= 8'h05;
		clear_all();
		check(setw, 0);
	endtask : t_setting

	task automatic t_link();
		@(posedge clk_i);
		per <= 24'h000578;
		run <= 1'h1;
		wait_ev();
		wait_ev();
		check(measured, 32'h578);
		check({lost, errw, miss}, 0);
		// one cycle past the window times out and counts as a miss
		@(posedge clk_i);
		per <= 24'h000579;
		wait_ev();
		check({lost, errw, miss}, 1);
		wait_ev();
		check({lost, miss}, 9'h102);
		// late periods time out, so a very short one trips the error threshold
		@(posedge clk_i);
		per <= 24'h000064;
		wait_ev();
		check(measured, 32'h64);
		check(errw, 1);
		@(posedge clk_i);
		run <= 1'h0;
		settle(1600);
		check(measured, 0);
		check(lost, 1);
	endtask : t_link

	task automatic t_leave();
		clear_all();
		check({lost, errw}, 0);
		@(posedge clk_i);
		servo_enabled_i <= 1'h1;
		set_state(4'h2);
		check(lost, 1);
	endtask : t_leave

	task automatic summarize();
		$display("errors=%0d n_checks=%0d", errors, n_checks);
		if (errors == 0 && n_checks > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask : summarize

	initial begin
		reset_i = 1'h1;
		net_state_i = 4'h0;
		servo_enabled_i = 1'h1;
		nominal_period_i = 24'h0003e8;
		fa = 8'h05;
		fb = 8'h0a;
		allowed = 8'h01;
		slave_description_file_i = 1'h0;
		clear_warnings_i = 1'h0;
		run = 1'h0;
		per = 24'h0003e8;
		repeat (3) @(posedge clk_i);
		reset_i <= 1'h0;
		settle(3);
		t_desc();
		t_setting();
		t_link();
		t_leave();
		summarize();
	end
endmodule : ssm_monitor_test

`default_nettype wire
